// *** rtl/instr_core_pkg.sv ***
/*
 * constants, reset values and the phase type shared by the decoder.
 * assumes a 12-bit program word and a 32-entry file register window.
 */
package instr_core_pkg;
   // -----------------------------------------------------------------
   // word layout
   // -----------------------------------------------------------------
   localparam int INSTR_W     = 12;
   localparam int PC_W        = 10;
   localparam int DATA_W      = 8;
   localparam int FADDR_W     = 5;
   localparam int DEST_BIT    = 5;
   localparam int PC_FORCE0   = 8;       // ninth program counter bit
   localparam int OSC_PER_CYC = 4;       // oscillator periods per cycle

   // -----------------------------------------------------------------
   // special addresses and fields
   // -----------------------------------------------------------------
   localparam logic [4:0] TIMER_ADDR  = 5'h01;
   localparam logic [4:0] PORT_ADDR   = 5'h06;
   localparam logic [2:0] DIR_OPERAND = 3'h6;
   localparam int         OPT_PSA_BIT = 3;   // 1: prescaler on watchdog

   // -----------------------------------------------------------------
   // values after reset
   // -----------------------------------------------------------------
   localparam logic [7:0] W_RST      = 8'h00;
   localparam logic [7:0] DIR_RST    = 8'hFF;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [9:0] PC_RST     = 10'h3FF;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
endpackage

// *** rtl/twelve_bit_instruction_decoder.sv ***
/*
 * decode and execute logic for the 12-bit instruction set.
 * assumes program memory presents instrWord for progAddr within the
 * instruction cycle, and the file register file answers fileRdata
 * combinationally for fileRaddr; port pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - every instruction is one 12-bit word: opcode plus operand fields
// - a cycle is four clocks; skips and branches spend two cycles
// - add-register sums accumulator and file, sets carry, digit, zero
// - destination bit 0 writes accumulator, 1 writes the file register
// - and-literal masks accumulator with literal, only zero flag moves
// - rotates go through carry, left or right, only carry changes
// - decrement/increment-skip forms skip when result zero, flags untouched
// - bit ops clear, set, skip-if-clear, skip-if-set; no flags
// - or and xor with register update only the zero flag
// - or and xor literal write accumulator and update zero flag
// - return-with-literal loads accumulator, pops stack, two cycles
// - standby and watchdog clear update timeout and powerdown flags
// - only the call forces the ninth program counter bit low
// - port read-modify-write uses sampled pin levels as source
// - direction load with operand six copies accumulator to latches
// - writes to the timer register clear its assigned prescaler
module twelve_bit_instruction_decoder (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [11:0] instrWord,
   output logic      [9:0]  progAddr,
   output logic      [4:0]  fileRaddr,
   input  wire logic [7:0]  fileRdata,
   output logic             fileWe,
   output logic      [4:0]  fileWaddr,
   output logic      [7:0]  fileWdata,
   input  wire logic [7:0]  portPins,
   output logic      [7:0]  dirLatch,
   output logic      [7:0]  optionReg,
   output logic      [7:0]  accReg,
   output logic             carryFlag,
   output logic             digitCarryFlag,
   output logic             zeroFlag,
   output logic             timeoutFlag,
   output logic             powerdownFlag,
   output logic             sleepMode,
   output logic             watchdogClr,
   output logic             prescalerClr
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   instr_core_pkg::phase_t phase_ff, nxt_phase;
   logic [9:0] pc_ff, nxt_pc, stack0_ff, nxt_stack0, stack1_ff, nxt_stack1;
   logic [7:0] w_ff, nxt_w, dir_ff, nxt_dir, opt_ff, nxt_opt;
   logic [7:0] pinMeta_ff, pinSync_ff, wdata_ff, nxt_wdata;
   logic [4:0] waddr_ff, nxt_waddr;
   logic       c_ff, nxt_c, dc_ff, nxt_dc, z_ff, nxt_z, to_ff, nxt_to;
   logic       pd_ff, nxt_pd, slp_ff, nxt_slp, we_ff, nxt_we;
   logic       flush_ff, nxt_flush, flStep_ff, nxt_flStep;
   logic       wdc_ff, nxt_wdc, psc_ff, nxt_psc;

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   logic [4:0] fAddr;
   logic [2:0] bitIdx;
   logic       dBit, exec;
   logic [7:0] src, res, aOp, bOp, k8;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic       cin, wrRes, updZ, skip, pcLoad;
   logic [9:0] pcTarget;
   assign fAddr  = instrWord[4:0];
   assign bitIdx = instrWord[7:5];
   assign dBit   = instrWord[instr_core_pkg::DEST_BIT];
   assign k8     = instrWord[7:0];
   assign exec   = (phase_ff == instr_core_pkg::PH_Q4) && !flush_ff && !slp_ff;
   // port operands come from the pins, not the output latch
   assign src    = (fAddr == instr_core_pkg::PORT_ADDR) ? pinSync_ff
                   : fileRdata;
   assign sum9   = {1'b0, aOp} + {1'b0, bOp} + {8'h00, cin};
   assign sum5   = {1'b0, aOp[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};

   // -----------------------------------------------------------------
   // execute: alu, flags, destination and program flow
   // -----------------------------------------------------------------
   always_comb begin
      aOp = w_ff; bOp = src; cin = 1'b0;
      res = src; wrRes = 1'b0; updZ = 1'b0;
      skip = 1'b0; pcLoad = 1'b0; pcTarget = pc_ff;
      nxt_w = w_ff; nxt_c = c_ff; nxt_dc = dc_ff;
      nxt_dir = dir_ff; nxt_opt = opt_ff; nxt_to = to_ff; nxt_pd = pd_ff;
      nxt_slp = slp_ff; nxt_stack0 = stack0_ff; nxt_stack1 = stack1_ff;
      nxt_wdc = 1'b0; nxt_psc = 1'b0; nxt_we = 1'b0;
      nxt_waddr = waddr_ff; nxt_wdata = wdata_ff; nxt_z = z_ff;
      // nothing commits outside the execute slot
      if (exec) casez (instrWord)
         12'b0000_0000_0010: nxt_opt = w_ff;
         12'b0000_0000_0011: begin
            nxt_to = 1'b1; nxt_pd = 1'b0; nxt_slp = 1'b1;
            nxt_wdc = 1'b1;
         end
         12'b0000_0000_0100: begin
            nxt_to = 1'b1; nxt_pd = 1'b1; nxt_wdc = 1'b1;
         end
         12'b0000_0000_0110: nxt_dir = w_ff;
         12'b0000_001?_????: begin res = w_ff; wrRes = 1'b1; end
         12'b0000_0100_0000: begin res = 8'h00; wrRes = 1'b1; updZ = 1'b1; end
         12'b0000_011?_????: begin res = 8'h00; wrRes = 1'b1; updZ = 1'b1; end
         12'b0000_10??_????, 12'b0001_11??_????: begin
            if (!instrWord[8]) begin      // subtract: f + ~w + 1
               aOp = src; bOp = ~w_ff; cin = 1'b1;
            end
            res = sum9[7:0]; wrRes = 1'b1; updZ = 1'b1;
            nxt_c = sum9[8]; nxt_dc = sum5[4];
         end
         12'b0000_11??_????: begin res = src - 8'h01; wrRes = 1'b1;
            updZ = 1'b1; end
         12'b0001_00??_????: begin res = w_ff | src; wrRes = 1'b1;
            updZ = 1'b1; end
         12'b0001_01??_????: begin res = w_ff & src; wrRes = 1'b1;
            updZ = 1'b1; end
         12'b0001_10??_????: begin res = w_ff ^ src; wrRes = 1'b1;
            updZ = 1'b1; end
         12'b0010_00??_????: begin res = src; wrRes = 1'b1; updZ = 1'b1; end
         12'b0010_01??_????: begin res = ~src; wrRes = 1'b1; updZ = 1'b1; end
         12'b0010_10??_????: begin res = src + 8'h01; wrRes = 1'b1;
            updZ = 1'b1; end
         12'b0010_11??_????, 12'b0011_11??_????: begin
            res = instrWord[8] ? src + 8'h01 : src - 8'h01;
            wrRes = 1'b1; skip = (res == 8'h00);
         end
         12'b0011_00??_????: begin
            res = {c_ff, src[7:1]}; wrRes = 1'b1; nxt_c = src[0];
         end
         12'b0011_01??_????: begin
            res = {src[6:0], c_ff}; wrRes = 1'b1; nxt_c = src[7];
         end
         12'b0011_10??_????: begin res = {src[3:0], src[7:4]};
            wrRes = 1'b1; end
         12'b0100_????_????: begin
            res = src & ~(8'h01 << bitIdx); wrRes = 1'b1; end
         12'b0101_????_????: begin
            res = src | (8'h01 << bitIdx); wrRes = 1'b1; end
         12'b0110_????_????: skip = !src[bitIdx];
         12'b0111_????_????: skip = src[bitIdx];
         12'b1000_????_????: begin
            nxt_w = k8; pcLoad = 1'b1; pcTarget = stack0_ff;
            nxt_stack0 = stack1_ff;
         end
         12'b1001_????_????: begin
            pcLoad = 1'b1; nxt_stack1 = stack0_ff;
            nxt_stack0 = pc_ff + 10'h001;
            pcTarget = {pc_ff[9], 1'b0, k8};
         end
         12'b101?_????_????: begin
            pcLoad = 1'b1; pcTarget = {pc_ff[9], instrWord[8:0]};
         end
         12'b1100_????_????: nxt_w = k8;
         12'b1101_????_????: begin nxt_w = w_ff | k8; updZ = 1'b1;
            res = w_ff | k8; end
         12'b1110_????_????: begin nxt_w = w_ff & k8; updZ = 1'b1;
            res = w_ff & k8; end
         12'b1111_????_????: begin nxt_w = w_ff ^ k8; updZ = 1'b1;
            res = w_ff ^ k8; end
         default: ;
      endcase
      // byte results: d selects accumulator or file register
      if (wrRes && (dBit || instrWord[11:10] == 2'b01)) begin // bit ops
         nxt_we = 1'b1; nxt_waddr = fAddr; nxt_wdata = res;
         // timer writes reset its prescaler when assigned
         nxt_psc = (fAddr == instr_core_pkg::TIMER_ADDR) &&
                   !opt_ff[instr_core_pkg::OPT_PSA_BIT];
      end else if (wrRes) begin
         nxt_w = res;
      end
      if (updZ) begin
         nxt_z = (res == 8'h00);
      end
   end

   // -----------------------------------------------------------------
   // sequencing: four phases per cycle, second cycle discarded
   // -----------------------------------------------------------------
   always_comb begin
      nxt_pc = pc_ff; nxt_flush = flush_ff; nxt_flStep = flStep_ff;
      case (phase_ff)
         instr_core_pkg::PH_Q1: nxt_phase = instr_core_pkg::PH_Q2;
         instr_core_pkg::PH_Q2: nxt_phase = instr_core_pkg::PH_Q3;
         instr_core_pkg::PH_Q3: nxt_phase = instr_core_pkg::PH_Q4;
         instr_core_pkg::PH_Q4: nxt_phase = instr_core_pkg::PH_Q1;
         default:               nxt_phase = instr_core_pkg::PH_Q1;
      endcase
      if (exec) begin
         nxt_pc = pcLoad ? pcTarget : pc_ff + 10'h001;
         nxt_flush = skip || pcLoad;
         nxt_flStep = skip;
      end else if (phase_ff == instr_core_pkg::PH_Q4 && flush_ff) begin
         // a skip still steps past the discarded word; a branch holds
         nxt_pc = flStep_ff ? pc_ff + 10'h001 : pc_ff;
         nxt_flush = 1'b0; nxt_flStep = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      pinMeta_ff <= portPins;        // two-stage pin synchroniser
      pinSync_ff <= pinMeta_ff;
      if (reset) begin
         phase_ff <= instr_core_pkg::PH_Q1; pc_ff <= instr_core_pkg::PC_RST;
         stack0_ff <= 10'h000; stack1_ff <= 10'h000;
         w_ff <= instr_core_pkg::W_RST; dir_ff <= instr_core_pkg::DIR_RST;
         opt_ff <= instr_core_pkg::OPTION_RST;
         c_ff <= 1'b0; dc_ff <= 1'b0; z_ff <= 1'b0;
         to_ff <= 1'b1; pd_ff <= 1'b1; slp_ff <= 1'b0;
         we_ff <= 1'b0; waddr_ff <= 5'h00; wdata_ff <= 8'h00;
         flush_ff <= 1'b0; flStep_ff <= 1'b0; wdc_ff <= 1'b0; psc_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase; pc_ff <= nxt_pc;
         stack0_ff <= nxt_stack0; stack1_ff <= nxt_stack1;
         w_ff <= nxt_w; dir_ff <= nxt_dir; opt_ff <= nxt_opt;
         c_ff <= nxt_c; dc_ff <= nxt_dc; z_ff <= nxt_z;
         to_ff <= nxt_to; pd_ff <= nxt_pd; slp_ff <= nxt_slp;
         we_ff <= nxt_we; waddr_ff <= nxt_waddr; wdata_ff <= nxt_wdata;
         flush_ff <= nxt_flush; flStep_ff <= nxt_flStep;
         wdc_ff <= nxt_wdc; psc_ff <= nxt_psc;
      end
   end

   assign progAddr = pc_ff;        assign fileRaddr = fAddr;
   assign fileWe = we_ff;          assign fileWaddr = waddr_ff;
   assign fileWdata = wdata_ff;    assign dirLatch = dir_ff;
   assign optionReg = opt_ff;      assign accReg = w_ff;
   assign carryFlag = c_ff;        assign digitCarryFlag = dc_ff;
   assign zeroFlag = z_ff;         assign timeoutFlag = to_ff;
   assign powerdownFlag = pd_ff;   assign sleepMode = slp_ff;
   assign watchdogClr = wdc_ff;    assign prescalerClr = psc_ff;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_quietCycle;
      flush_ff [*4];
   endsequence
   property p_phase; @(posedge clk_sys) disable iff (reset)
      phase_ff == instr_core_pkg::PH_Q4 |=> phase_ff ==
         instr_core_pkg::PH_Q1 ##3 phase_ff == instr_core_pkg::PH_Q4;
   endproperty
   a_phase: assert property (p_phase) else $error("phase order");
   property p_branchTwo; @(posedge clk_sys) disable iff (reset)
      exec && instrWord[11:9] == 3'b101 |=> s_quietCycle ##1 !flush_ff;
   endproperty
   a_branchTwo: assert property (p_branchTwo)
      else $error("branch not two cycles");
   property p_addFlags; @(posedge clk_sys) disable iff (reset)
      exec && instrWord[11:6] == 6'b000111 |=>
         carryFlag == (({1'b0, $past(accReg)} + {1'b0, $past(src)}) > 9'h0FF)
         && zeroFlag == ($past(accReg) + $past(src) == 8'h00);
   endproperty
   a_addFlags: assert property (p_addFlags) else $error("add flags");
   property p_andLit; @(posedge clk_sys) disable iff (reset)
      exec && instrWord[11:8] == 4'hE |=>
         accReg == ($past(accReg) & $past(instrWord[7:0])) &&
         $stable(carryFlag);
   endproperty
   a_andLit: assert property (p_andLit) else $error("and literal");
   property p_destFile; @(posedge clk_sys) disable iff (reset)
      exec && instrWord[11:10] == 2'b00 && instrWord[9:6] != 4'h0 && dBit
      |=> fileWe && fileWaddr == $past(fAddr) && $stable(accReg);
   endproperty
   a_destFile: assert property (p_destFile) else $error("dest file");
   property p_callPc; @(posedge clk_sys) disable iff (reset)
      exec && instrWord[11:8] == 4'h9 |=>
         (!progAddr[instr_core_pkg::PC_FORCE0]) and s_quietCycle;
   endproperty
   a_callPc: assert property (p_callPc) else $error("call pc bit");
   property p_dirLoad; @(posedge clk_sys) disable iff (reset)
      exec && instrWord == 12'h006 |=> dirLatch == $past(accReg);
   endproperty
   a_dirLoad: assert property (p_dirLoad) else $error("dir load");
   property p_sleep; @(posedge clk_sys) disable iff (reset)
      exec && instrWord == 12'h003 |=> !powerdownFlag && timeoutFlag
         && sleepMode ##1 sleepMode;
   endproperty
   a_sleep: assert property (p_sleep) else $error("standby flags");
   property p_presc; @(posedge clk_sys) disable iff (reset)
      prescalerClr |-> fileWe && fileWaddr == instr_core_pkg::TIMER_ADDR
         && !optionReg[instr_core_pkg::OPT_PSA_BIT];
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler clr");
endmodule

`default_nettype wire

// *** tb/prog_mem_model.sv ***
/*
 * program memory model: hands out one 12-bit word for progAddr.
 * assumes the bench fills rom before reset is released.
 */
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------------------------------
// word store
// -------------------------------------------------------------------
module prog_mem_model (
   input  wire logic        clk_sys,
   input  wire logic [9:0]  progAddr,
   output logic      [11:0] instrWord
);
   logic [11:0] rom [0:1023];
   initial instrWord = 12'h000;
   // whole word per address, moved off the sampling edge
   always @(negedge clk_sys) begin
      instrWord <= rom[progAddr];
   end
endmodule
`default_nettype wire

// *** tb/test_twelve_bit_instruction_decoder.sv ***
/*
 * self-checking bench: builds a program, notes each expected file write
 * with flags, prescaler pulse and cycle position, and compares on fileWe.
 * assumes the decoder contract of one instruction per four clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module test_twelve_bit_instruction_decoder;
   typedef struct {
      logic [4:0] a;
      logic [7:0] d;
      logic [2:0] f;
      logic       p;
      int         cy;
   } note_t;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [11:0] instrWord;
   logic [9:0]  progAddr, pa, pc, rp;
   logic [4:0]  fileRaddr, fileWaddr;
   logic [7:0]  fileRdata, fileWdata, portPins, dirLatch, optionReg, accReg;
   logic        fileWe, carryFlag, digitCarryFlag, zeroFlag, timeoutFlag;
   logic        powerdownFlag, sleepMode, watchdogClr, prescalerClr;
   logic [7:0]  fileMem [0:31];
   logic [7:0]  fs [0:31];
   logic [7:0]  w, r, a, b, k, dv, o, rv;
   logic [2:0]  bb;
   logic        c, dc, z, psOn, dual;
   note_t       q [$];
   note_t       e;
   int          cy, edges, lastE, nWd, n_fail, checked;
   int          lastCy = -1;

   always #10 clk_sys = ~clk_sys;

   twelve_bit_instruction_decoder dut (
      .clk_sys(clk_sys), .reset(reset), .instrWord(instrWord),
      .progAddr(progAddr), .fileRaddr(fileRaddr), .fileRdata(fileRdata),
      .fileWe(fileWe), .fileWaddr(fileWaddr), .fileWdata(fileWdata),
      .portPins(portPins), .dirLatch(dirLatch), .optionReg(optionReg),
      .accReg(accReg), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
      .digitCarryFlag(digitCarryFlag), .timeoutFlag(timeoutFlag),
      .powerdownFlag(powerdownFlag), .sleepMode(sleepMode),
      .watchdogClr(watchdogClr), .prescalerClr(prescalerClr));
   prog_mem_model u_mem (.clk_sys(clk_sys), .progAddr(progAddr),
      .instrWord(instrWord));

   // -----------------------------------------------------------------
   // file register store
   // -----------------------------------------------------------------
   // write lands well before the next instruction reads it
   assign fileRdata = fileMem[fileRaddr];
   always @(posedge clk_sys) begin
      if (fileWe === 1'b1) fileMem[fileWaddr] <= fileWdata;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
         n_fail++;
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // note a write at the cycle of the instruction about to be stored
   task note(input logic [4:0] f, input logic [7:0] d, input logic p);
      q.push_back('{f, d, {c, dc, z}, p, cy});
      fs[f] = d;
   endtask
   // dual also stores the word where a cleared bit 8 would lead
   task put(input logic [11:0] wd, input int n);
      u_mem.rom[pc] = wd;
      if (dual) u_mem.rom[pc ^ 10'h100] = wd;
      pc = pc + 10'h001;
      cy = cy + n;
   endtask
   task byt(input logic [5:0] op, input logic [4:0] f, input logic d,
            input logic [7:0] v, input logic uz, input int n);
      if (uz) z = (v == 8'h00);
      if (d) note(f, v, psOn && f == 5'h01);
      else w = v;
      put({op, d, f}, n);
   endtask
   task lit(input logic [3:0] op, input logic [7:0] kk, input logic [7:0] v,
            input logic uz);
      if (uz) z = (v == 8'h00);
      w = v;
      put({op, kk}, 1);
   endtask
   task mv(input logic [4:0] f);
      byt(6'h00, f, 1'b1, w, 1'b0, 1);
   endtask
   task add(input logic [4:0] f, input logic d);
      {c, r} = w + fs[f];
      dc = (w[3:0] + fs[f][3:0]) > 5'd15;
      byt(6'h07, f, d, r, 1'b1, 1);
   endtask

   // -----------------------------------------------------------------
   // result watcher
   // -----------------------------------------------------------------
   always @(posedge clk_sys) begin
      edges++;
      if (!reset && watchdogClr === 1'b1) nWd++;
      if (!reset && fileWe === 1'b1) begin
         if (q.size() == 0) chk("unexpected write", 0, 1);
         else begin
            e = q.pop_front();
            chk("write addr", e.a, fileWaddr);
            chk("write data", e.d, fileWdata);
            chk("c dc z", e.f, {carryFlag, digitCarryFlag, zeroFlag});
            chk("prescaler clear", e.p, prescalerClr);
            if (lastCy >= 0) chk("gap", 4 * (e.cy - lastCy), edges - lastE);
            lastCy = e.cy;
            lastE = edges;
         end
      end
   end

   // watchdog cuts a hang short
   initial begin
      #80000;
      n_fail++;
      end_of_test();
   end

   // -----------------------------------------------------------------
   // program, reset and final checks
   // -----------------------------------------------------------------
   initial begin
      portPins = 8'h00;
      void'($urandom(32'h278E20A2));
      {a, b, k, portPins} = $urandom;
      {dv, o, rv} = $urandom;
      o = o & 8'hF7;
      bb = $urandom;
      for (int i = 0; i < 1024; i++) u_mem.rom[i] = 12'h000;
      for (int i = 0; i < 32; i++) fileMem[i] = 8'h00;
      for (int i = 0; i < 32; i++) fs[i] = 8'h00;
      fileMem[6] = ~portPins;
      {w, c, dc, z, psOn, dual, pc, cy} = '0;
      cy = 1;
      lit(4'hC, a, a, 1'b0);
      mv(5'h10);
      mv(5'h01);
      lit(4'hC, b, b, 1'b0);
      add(5'h10, 1'b0);
      mv(5'h11);
      add(5'h10, 1'b1);
      lit(4'hE, k, w & k, 1'b1);
      mv(5'h12);
      lit(4'hD, k, w | k, 1'b1);
      lit(4'hF, w, 8'h00, 1'b1);
      mv(5'h12);
      byt(6'h04, 5'h10, 1'b0, w | fs[16], 1'b1, 1);
      byt(6'h06, 5'h11, 1'b1, w ^ fs[17], 1'b1, 1);
      r = {fs[16][6:0], c};
      c = fs[16][7];
      byt(6'h0D, 5'h10, 1'b1, r, 1'b0, 1);
      r = {c, fs[16][7:1]};
      c = fs[16][0];
      byt(6'h0C, 5'h10, 1'b0, r, 1'b0, 1);
      mv(5'h12);
      byt(6'h0B, 5'h13, 1'b1, 8'hFF, 1'b0, 1);
      byt(6'h0F, 5'h13, 1'b1, 8'h00, 1'b0, 2);
      put(12'h035, 0);
      note(5'h13, 8'h01 << bb, 1'b0);
      put({4'h5, bb, 5'h13}, 1);
      note(5'h13, 8'h01 << bb, 1'b0);
      put({4'h4, bb + 3'h1, 5'h13}, 1);
      put({4'h7, bb, 5'h13}, 2);
      put(12'h035, 0);
      put({4'h6, bb, 5'h13}, 1);
      put({4'h6, bb + 3'h1, 5'h13}, 2);
      put(12'h035, 0);
      byt(6'h08, 5'h06, 1'b1, portPins, 1'b1, 1);
      put({3'b101, 9'h1A0}, 2);
      pc = 10'h1A0;
      put({4'h9, 8'h60}, 2);
      rp = pc;
      u_mem.rom[10'h160] = {4'h8, ~rv};
      pc = 10'h060;
      put({4'h8, rv}, 2);
      w = rv;
      pc = rp;
      dual = 1'b1;
      mv(5'h15);
      put({3'b101, 9'h0D0}, 2);
      dual = 1'b0;
      pc = 10'h0D0;
      lit(4'hC, dv, dv, 1'b0);
      put(12'h006, 1);
      lit(4'hC, o, o, 1'b0);
      put(12'h005, 1);
      put(12'h002, 1);
      psOn = 1'b1;
      mv(5'h01);
      put(12'h004, 1);
      put(12'h003, 1);
      put(12'h035, 0);
      // reset held three clocks, values checked before release
      repeat (3) @(negedge clk_sys);
      chk("pc reset", instr_core_pkg::PC_RST, progAddr);
      chk("acc reset", instr_core_pkg::W_RST, accReg);
      chk("dir reset", instr_core_pkg::DIR_RST, dirLatch);
      chk("option reset", instr_core_pkg::OPTION_RST, optionReg);
      chk("to pd reset", 2'b11, {timeoutFlag, powerdownFlag});
      reset = 1'b0;
      repeat (4 * cy + 40) @(negedge clk_sys);
      chk("notes left", 0, q.size());
      chk("standby", 1'b1, sleepMode);
      chk("to pd", 2'b10, {timeoutFlag, powerdownFlag});
      chk("watchdog pulses", 2, nWd);
      chk("direction", dv, dirLatch);
      chk("option", o, optionReg);
      chk("acc", w, accReg);
      pa = progAddr;
      repeat (8) @(negedge clk_sys);
      chk("pc frozen", pa, progAddr);
      end_of_test();
   end
endmodule
`default_nettype wire
